// ==== split_autoreload_timer.sv ====
`timescale 1ns/1ns
module split_autoreload_timer
	import split_timer_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata_q,
	input  wire logic       high_byte_clock_select,
	input  wire logic       low_byte_clock_select,
	input  wire logic       timer_irq_enable,
	input  wire logic       ext_osc,
	output logic            timer_irq_q
);

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0] count_low_byte_q;
	logic [7:0] count_high_byte_q;
	logic [7:0] reload_low_byte_q;
	logic [7:0] reload_high_byte_q;
	logic       high_overflow_flag_q;
	logic       low_overflow_flag_q;
	logic       low_overflow_irq_enable_q;
	logic       split_mode_select_q;
	logic       run_control_q;
	logic       external_clock_select_q;
	logic       tick_sys_div;
	logic       tick_ext_div;

	// Timebase selection, shared by both bytes
	function automatic logic pick_tick(input logic byte_sel, input logic ext_sel,
			input logic sys_div, input logic ext_div);
		pick_tick = byte_sel ? 1'b1 : (ext_sel ? ext_div : sys_div);
	endfunction

	split_timer_timebase u_timebase (
		.core_clk     (core_clk),
		.rst          (rst),
		.ext_osc      (ext_osc),
		.tick_sys_div (tick_sys_div),
		.tick_ext_div (tick_ext_div)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Decode and counting

	// Write strobes
	wire        we_control = sfr_wr & (sfr_addr == ADDR_TIMER_CONTROL);
	wire        we_rld_low = sfr_wr & (sfr_addr == ADDR_RELOAD_LOW);
	wire        we_rld_hi  = sfr_wr & (sfr_addr == ADDR_RELOAD_HIGH);
	wire        we_cnt_low = sfr_wr & (sfr_addr == ADDR_COUNT_LOW);
	wire        we_cnt_hi  = sfr_wr & (sfr_addr == ADDR_COUNT_HIGH);

	// Per-byte timebase; one external select covers both
	wire        tick_low   = pick_tick(low_byte_clock_select, external_clock_select_q,
			tick_sys_div, tick_ext_div);
	wire        tick_high  = pick_tick(high_byte_clock_select, external_clock_select_q,
			tick_sys_div, tick_ext_div);

	// Low byte free-runs in split mode; run bit gates the rest
	wire        step_low   = split_mode_select_q ? tick_low : (run_control_q & tick_low);
	wire        wrap_low   = step_low & (count_low_byte_q == BYTE_MAX);
	// High byte steps on its own tick in split, on the low carry in 16-bit
	wire        step_high  = split_mode_select_q ? (run_control_q & tick_high) : wrap_low;
	wire        wrap_high  = step_high & (count_high_byte_q == BYTE_MAX);

	// Low reload: always in split, only on full wrap in 16-bit
	wire        low_reload = split_mode_select_q | wrap_high;
	wire [7:0]  count_low_byte_d = we_cnt_low ? sfr_wdata :
			wrap_low ? (low_reload ? reload_low_byte_q : BYTE_ZERO) :
			step_low ? count_low_byte_q + 8'h01 : count_low_byte_q;
	wire [7:0]  count_high_byte_d = we_cnt_hi ? sfr_wdata :
			wrap_high ? reload_high_byte_q :
			step_high ? count_high_byte_q + 8'h01 : count_high_byte_q;

	// Hardware set beats a software clear in the same cycle
	wire        high_flag_d = (we_control ? sfr_wdata[BIT_HIGH_OVERFLOW] : high_overflow_flag_q)
			| wrap_high;
	wire        low_flag_d  = (we_control ? sfr_wdata[BIT_LOW_OVERFLOW] : low_overflow_flag_q)
			| wrap_low;

	// Interrupt request from either flag, gated by the enables
	wire        irq_d = timer_irq_enable & (high_flag_d | (low_flag_d & low_overflow_irq_enable_q));

	// Control readback; unused positions stay zero
	wire [7:0]  control_read = {high_overflow_flag_q, low_overflow_flag_q, low_overflow_irq_enable_q,
			1'b0, split_mode_select_q, run_control_q, 1'b0, external_clock_select_q};

	// Read mux; unmapped addresses read zero
	wire [7:0]  rdata_d = (sfr_addr == ADDR_TIMER_CONTROL) ? control_read :
			(sfr_addr == ADDR_RELOAD_LOW)  ? reload_low_byte_q :
			(sfr_addr == ADDR_RELOAD_HIGH) ? reload_high_byte_q :
			(sfr_addr == ADDR_COUNT_LOW)   ? count_low_byte_q :
			(sfr_addr == ADDR_COUNT_HIGH)  ? count_high_byte_q : 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// State

	// Count and reload bytes; software write wins over counting
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_low_byte_q   <= COUNT_RESET;
			count_high_byte_q  <= COUNT_RESET;
			reload_low_byte_q  <= RELOAD_RESET;
			reload_high_byte_q <= RELOAD_RESET;
		end else begin
			count_low_byte_q   <= count_low_byte_d;
			count_high_byte_q  <= count_high_byte_d;
			reload_low_byte_q  <= we_rld_low ? sfr_wdata : reload_low_byte_q;
			reload_high_byte_q <= we_rld_hi ? sfr_wdata : reload_high_byte_q;
		end
	end

	// Control bits; bits 4 and 1 are never stored
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			{high_overflow_flag_q, low_overflow_flag_q, low_overflow_irq_enable_q,
				split_mode_select_q, run_control_q, external_clock_select_q} <= '0;
		end else begin
			high_overflow_flag_q <= high_flag_d;
			low_overflow_flag_q  <= low_flag_d;
			if (we_control) begin
				low_overflow_irq_enable_q <= sfr_wdata[BIT_LOW_IRQ_ENABLE];
				split_mode_select_q       <= sfr_wdata[BIT_SPLIT_MODE];
				run_control_q             <= sfr_wdata[BIT_RUN_CONTROL];
				external_clock_select_q   <= sfr_wdata[BIT_EXT_CLOCK_SEL];
			end
		end
	end

	// Registered outputs; read data lags the address by one edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sfr_rdata_q <= 8'h00;
			timer_irq_q <= 1'b0;
		end else begin
			sfr_rdata_q <= rdata_d;
			timer_irq_q <= irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_wrap16_reload: assert property (
		(!split_mode_select_q && run_control_q && tick_low && !we_cnt_low && !we_cnt_hi
			&& count_low_byte_q == 8'hFF && count_high_byte_q == 8'hFF)
		|=> ({count_high_byte_q, count_low_byte_q} == $past({reload_high_byte_q, reload_low_byte_q}))
			&& high_overflow_flag_q && low_overflow_flag_q)
		else $error("16-bit wrap did not reload or flag");

	a_split_high_wrap: assert property (
		(split_mode_select_q && run_control_q && tick_high && !we_cnt_hi && count_high_byte_q == 8'hFF)
		|=> high_overflow_flag_q && count_high_byte_q == $past(reload_high_byte_q))
		else $error("split high wrap missed");

	a_low_wrap_flag: assert property (
		wrap_low |=> low_overflow_flag_q)
		else $error("low wrap did not set flag");

	a_flag_sticky: assert property (
		(high_overflow_flag_q && !we_control)[*2] |=> high_overflow_flag_q)
		else $error("high flag cleared by hardware");

	// A clearing write in the same cycle drops the request, so it is excluded here
	a_irq_high: assert property (
		(timer_irq_enable && high_overflow_flag_q && !we_control) |=> timer_irq_q)
		else $error("no request for high flag");

	a_irq_low: assert property (
		(timer_irq_enable && low_overflow_flag_q && low_overflow_irq_enable_q && !we_control) |=> timer_irq_q)
		else $error("no request for low flag");

	a_split_low_free: assert property (
		(split_mode_select_q && !run_control_q && low_byte_clock_select && !we_cnt_low
			&& count_low_byte_q != 8'hFF) |=> count_low_byte_q == $past(count_low_byte_q) + 8'h01)
		else $error("split low byte not free running");

	a_stopped_hold: assert property (
		(!split_mode_select_q && !run_control_q && !we_cnt_low && !we_cnt_hi)
		|=> $stable(count_low_byte_q) && $stable(count_high_byte_q))
		else $error("stopped 16-bit counter moved");

	a_system_clock_step: assert property (
		(!split_mode_select_q && run_control_q && low_byte_clock_select && !we_cnt_low && !we_cnt_hi
			&& count_low_byte_q == 8'hFF && count_high_byte_q != 8'hFF)
		|=> count_low_byte_q == 8'h00 && count_high_byte_q == $past(count_high_byte_q) + 8'h01)
		else $error("carry into high byte missed");

	a_unused_zero: assert property (
		(sfr_addr == ADDR_TIMER_CONTROL) |=> sfr_rdata_q[4] == 1'b0 && sfr_rdata_q[1] == 1'b0)
		else $error("unused control bits read nonzero");

	a_div12_space: assert property (
		tick_sys_div |=> !tick_sys_div [*8] ##0 1)
		else $error("clock/12 tick too frequent");

	////////////////////////////////////////////////////////////////////////////////
	// Further checks

	// Flags and request; a flag may only fall through a control write
	a_high_wrap_flag: assert property (
		wrap_high |=> high_overflow_flag_q)
		else $error("high wrap did not set flag");

	a_low_sticky: assert property (
		(low_overflow_flag_q && !we_control) |=> low_overflow_flag_q)
		else $error("low flag cleared by hardware");

	a_flag_clear: assert property (
		(we_control && !sfr_wdata[BIT_HIGH_OVERFLOW] && !wrap_high) |=> !high_overflow_flag_q)
		else $error("software clear of high flag lost");

	a_irq_quiet: assert property (
		!timer_irq_enable |=> !timer_irq_q)
		else $error("request while timer interrupt disabled");

	// Low flag alone must stay silent while its own enable is clear
	a_low_masked: assert property (
		(!low_overflow_irq_enable_q && !high_overflow_flag_q && !we_control && !wrap_high) |=> !timer_irq_q)
		else $error("masked low flag raised a request");

	// Counting and reload
	a_split_low_reload: assert property (
		(split_mode_select_q && tick_low && !we_cnt_low && count_low_byte_q == BYTE_MAX)
		|=> count_low_byte_q == $past(reload_low_byte_q) && low_overflow_flag_q)
		else $error("split low byte did not reload");

	a_split_no_carry: assert property (
		(split_mode_select_q && wrap_low && !(run_control_q && tick_high) && !we_cnt_hi)
		|=> $stable(count_high_byte_q))
		else $error("split low wrap carried into high byte");

	a_split_high_gate: assert property (
		(split_mode_select_q && !run_control_q && !we_cnt_hi) |=> $stable(count_high_byte_q))
		else $error("split high byte moved while stopped");

	a_wide_carry_only: assert property (
		(!split_mode_select_q && !wrap_low && !we_cnt_hi) |=> $stable(count_high_byte_q))
		else $error("16-bit high byte moved without carry");

	a_wide_step: assert property (
		(!split_mode_select_q && run_control_q && low_byte_clock_select && !we_cnt_low
			&& count_low_byte_q != BYTE_MAX) |=> count_low_byte_q == $past(count_low_byte_q) + 8'h01)
		else $error("16-bit low byte did not step");

	// Register access; read data trails the address by one edge
	a_low_write: assert property (
		we_cnt_low |=> count_low_byte_q == $past(sfr_wdata))
		else $error("count low write lost");

	a_high_write: assert property (
		we_cnt_hi |=> count_high_byte_q == $past(sfr_wdata))
		else $error("count high write lost");

	a_reload_low_write: assert property (
		we_rld_low |=> reload_low_byte_q == $past(sfr_wdata))
		else $error("reload low write lost");

	a_reload_high_write: assert property (
		we_rld_hi |=> reload_high_byte_q == $past(sfr_wdata))
		else $error("reload high write lost");

	a_count_read: assert property (
		(sfr_addr == ADDR_COUNT_HIGH) |=> sfr_rdata_q == $past(count_high_byte_q))
		else $error("count high readback wrong");

	a_reload_read: assert property (
		(sfr_addr == ADDR_RELOAD_HIGH) |=> sfr_rdata_q == $past(reload_high_byte_q))
		else $error("reload high readback wrong");

	a_control_read: assert property (
		(sfr_addr == ADDR_TIMER_CONTROL) |=> sfr_rdata_q[BIT_RUN_CONTROL] == $past(run_control_q))
		else $error("control readback wrong");

	// Timebase choice; a byte without its tick must hold still
	a_div_select: assert property (
		(!low_byte_clock_select && !external_clock_select_q && !tick_sys_div && !we_cnt_low)
		|=> $stable(count_low_byte_q))
		else $error("low byte moved without clock/12 tick");

	a_ext_select: assert property (
		(split_mode_select_q && !high_byte_clock_select && external_clock_select_q && !tick_ext_div
			&& !we_cnt_hi) |=> $stable(count_high_byte_q))
		else $error("split high byte moved without external tick");

	// Synchronised edges are at least two cycles apart, so eight rises span far more than eight cycles
	a_ext_tick_space: assert property (
		tick_ext_div |=> !tick_ext_div [*8] ##0 1)
		else $error("external/8 tick too frequent");

endmodule

// ==== split_timer_pkg.sv ====
package split_timer_pkg;

	// Register addresses in the processor's special-function space
	localparam logic [7:0] ADDR_TIMER_CONTROL   = 8'h91;
	localparam logic [7:0] ADDR_RELOAD_LOW      = 8'h92;
	localparam logic [7:0] ADDR_RELOAD_HIGH     = 8'h93;
	localparam logic [7:0] ADDR_COUNT_LOW       = 8'h94;
	localparam logic [7:0] ADDR_COUNT_HIGH      = 8'h95;

	// Control register field positions
	localparam int BIT_HIGH_OVERFLOW  = 7;
	localparam int BIT_LOW_OVERFLOW   = 6;
	localparam int BIT_LOW_IRQ_ENABLE = 5;
	localparam int BIT_SPLIT_MODE     = 3;
	localparam int BIT_RUN_CONTROL    = 2;
	localparam int BIT_EXT_CLOCK_SEL  = 0;

	// Reset values and byte limits
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] RELOAD_RESET  = 8'h00;
	localparam logic [7:0] COUNT_RESET   = 8'h00;
	localparam logic [7:0] BYTE_MAX      = 8'hFF;
	localparam logic [7:0] BYTE_ZERO     = 8'h00;

	// Timebase dividers
	localparam int SYS_CLOCK_DIVIDE = 12;
	localparam int EXT_CLOCK_DIVIDE = 8;

endpackage

// ==== split_timer_timebase.sv ====
`timescale 1ns/1ns
// Divided timebases: system clock / 12 and synchronised external clock / 8
module split_timer_timebase
	import split_timer_pkg::*;
#(
	parameter int SYS_DIV = SYS_CLOCK_DIVIDE,
	parameter int EXT_DIV = EXT_CLOCK_DIVIDE
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic ext_osc,
	output logic      tick_sys_div,
	output logic      tick_ext_div
);

	localparam int SW = $clog2(SYS_DIV);
	localparam int EW = $clog2(EXT_DIV);
	localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
	localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);

	logic [SW-1:0] sys_cnt_q;
	logic [EW-1:0] ext_cnt_q;
	logic          ext_meta_q;
	logic          ext_sync_q;
	logic          ext_prev_q;
	wire           ext_rise = ext_sync_q & ~ext_prev_q;
	wire           sys_last = (sys_cnt_q == SYS_LAST);
	wire           ext_last = ext_rise & (ext_cnt_q == EXT_LAST);

	// Two flops before any edge logic; the oscillator must not outrun core_clk
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ext_meta_q <= 1'b0;
			ext_sync_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			ext_meta_q <= ext_osc;
			ext_sync_q <= ext_meta_q;
			ext_prev_q <= ext_sync_q;
		end
	end

	// Free-running dividers; each tick is one core_clk wide
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sys_cnt_q    <= '0;
			ext_cnt_q    <= '0;
			tick_sys_div <= 1'b0;
			tick_ext_div <= 1'b0;
		end else begin
			sys_cnt_q    <= sys_last ? '0 : sys_cnt_q + 1'b1;
			ext_cnt_q    <= ext_rise ? (ext_last ? '0 : ext_cnt_q + 1'b1) : ext_cnt_q;
			tick_sys_div <= sys_last;
			tick_ext_div <= ext_last;
		end
	end

endmodule

// ==== split_autoreload_timer_bench.sv ====
`timescale 1ns/1ns
module split_autoreload_timer_bench;
	import split_timer_pkg::*;

	logic       core_clk, rst, sfr_wr, hs, ls, irq_en, ext_osc, timer_irq_q;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q;
	int         errors = 0, compares = 0, cycles = 0;

	split_autoreload_timer i_split_autoreload_timer (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .high_byte_clock_select(hs),
		.low_byte_clock_select(ls), .timer_irq_enable(irq_en), .ext_osc(ext_osc), .timer_irq_q(timer_irq_q));

////////////////////////////////////////////////////////////////////////////////
	// 10 MHz clock and a hang guard well above the expected run length
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			conclude();
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// Shared helpers; callers other than the hang guard enter just after a falling edge
	task automatic conclude();
		$display("Comparisons %0d, errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Idle edge after each write so the strobe never toggles twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge core_clk);
		sfr_wr = 1'b0;
		@(negedge core_clk);
	endtask

	// Read data shows the register as it stood at the sampling edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		sfr_addr = a;
		@(negedge core_clk);
		check(name, exp, sfr_rdata_q);
	endtask

	// Low select gates exact tick counts while the external source is idle
	task automatic tick(input int n);
		ls = 1'b1;
		repeat (n) @(negedge core_clk);
		ls = 1'b0;
	endtask

////////////////////////////////////////////////////////////////////////////////
	task automatic s_reset();
		for (int a = 8'h90; a <= 8'h96; a++) begin
			rd(8'(a), 8'h00, "reset value");
		end
		check("irq", 8'h00, {7'h00, timer_irq_q});
		wr(ADDR_TIMER_CONTROL, 8'h12);
		rd(ADDR_TIMER_CONTROL, 8'h00, "unused bits");
		wr(ADDR_RELOAD_LOW, 8'hA5);
		rd(ADDR_RELOAD_LOW, 8'hA5, "reload low");
		ls = 1'b1;
		wr(ADDR_COUNT_HIGH, 8'h5A);
		rd(ADDR_COUNT_HIGH, 8'h5A, "stopped count");
		ls = 1'b0;
	endtask

	task automatic s_wide();
		irq_en = 1'b1;
		wr(ADDR_RELOAD_LOW, 8'h34);
		wr(ADDR_RELOAD_HIGH, 8'h12);
		wr(ADDR_COUNT_LOW, 8'hFF);
		wr(ADDR_COUNT_HIGH, 8'h00);
		wr(ADDR_TIMER_CONTROL, 8'h05);
		tick(1);
		rd(ADDR_COUNT_LOW, 8'h00, "carry low");
		rd(ADDR_COUNT_HIGH, 8'h01, "carry high");
		rd(ADDR_TIMER_CONTROL, 8'h45, "low flag");
		check("irq masked", 8'h00, {7'h00, timer_irq_q});
		wr(ADDR_COUNT_LOW, 8'hFE);
		wr(ADDR_COUNT_HIGH, 8'hFF);
		tick(3);
		rd(ADDR_COUNT_LOW, 8'h35, "reload low");
		rd(ADDR_COUNT_HIGH, 8'h12, "reload high");
		rd(ADDR_TIMER_CONTROL, 8'hC5, "high flag");
		check("irq high", 8'h01, {7'h00, timer_irq_q});
		repeat (20) @(negedge core_clk);
		rd(ADDR_TIMER_CONTROL, 8'hC5, "flags kept");
		wr(ADDR_TIMER_CONTROL, 8'h00);
		rd(ADDR_TIMER_CONTROL, 8'h00, "flags cleared");
		check("irq cleared", 8'h00, {7'h00, timer_irq_q});
	endtask

	// High select on system clock while run is off: only the low byte may move
	task automatic s_split();
		wr(ADDR_RELOAD_LOW, 8'h10);
		wr(ADDR_RELOAD_HIGH, 8'h20);
		wr(ADDR_COUNT_LOW, 8'hFE);
		wr(ADDR_COUNT_HIGH, 8'hFF);
		wr(ADDR_TIMER_CONTROL, 8'h29);
		hs = 1'b1;
		tick(3);
		hs = 1'b0;
		rd(ADDR_COUNT_HIGH, 8'hFF, "high gated");
		rd(ADDR_COUNT_LOW, 8'h11, "split low");
		rd(ADDR_TIMER_CONTROL, 8'h69, "split low flag");
		check("irq low", 8'h01, {7'h00, timer_irq_q});
		wr(ADDR_TIMER_CONTROL, 8'h6D);
		hs = 1'b1;
		@(negedge core_clk);
		hs = 1'b0;
		rd(ADDR_COUNT_HIGH, 8'h20, "split high");
		rd(ADDR_COUNT_LOW, 8'h11, "low idle");
		rd(ADDR_TIMER_CONTROL, 8'hED, "split high flag");
	endtask

	task automatic s_bases();
		wr(ADDR_TIMER_CONTROL, 8'h05);
		wr(ADDR_COUNT_LOW, 8'h00);
		wr(ADDR_COUNT_HIGH, 8'h00);
		wr(ADDR_TIMER_CONTROL, 8'h04);
		repeat (118) @(negedge core_clk);
		wr(ADDR_TIMER_CONTROL, 8'h05);
		rd(ADDR_COUNT_LOW, 8'h0A, "divide by 12");
		wr(ADDR_COUNT_LOW, 8'h00);
		// Slow external source, each level two system cycles long
		repeat (64) begin
			ext_osc = 1'b1;
			repeat (2) @(negedge core_clk);
			ext_osc = 1'b0;
			repeat (2) @(negedge core_clk);
		end
		repeat (8) @(negedge core_clk);
		rd(ADDR_COUNT_LOW, 8'h08, "external by 8");
	endtask

////////////////////////////////////////////////////////////////////////////////
	// Reset for ten cycles, then every scenario in turn
	initial begin
		rst = 1'b1;
		sfr_wr = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		hs = 1'b0;
		ls = 1'b0;
		irq_en = 1'b0;
		ext_osc = 1'b0;
		repeat (10) @(negedge core_clk);
		rst = 1'b0;
		s_reset();
		s_wide();
		s_split();
		s_bases();
		conclude();
	end
endmodule
